/* rtl/cmt_ctrl.sv */
// Purpose: CAN master control, master status, transmit status and priority
// Assumes: bit_tick marks each bit sample point; can_rx is an async pin
// Notes: Zero-wait APB reads return data captured in the setup cycle
//
// Register access over APB and the address map were chosen for this implementation.
`timescale 1ns/1ps
`include "cmt_params.svh"
module cmt_ctrl #(
    parameter int ID_W = 29
) (
    input  wire logic              pclk,
    input  wire logic              presetn,
    input  wire logic [7:0]        paddr,
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [31:0]       pwdata,
    input  wire logic [3:0]        pstrb,
    output logic [31:0]            prdata,
    output logic                   pready,
    output logic                   pslverr,
    input  wire logic              can_rx,
    input  wire logic              bit_tick,
    input  wire logic              bus_busy,
    input  wire logic [8:0]        tx_error_counter,
    input  wire logic [3:0]        err_status_set,
    input  wire logic [3:0]        err_status_en,
    input  wire logic              wakeup_irq_enable,
    input  wire logic              error_irq_enable,
    input  wire logic              role_rx,
    input  wire logic              role_tx,
    input  wire logic [2:0]        mb_tx_req,
    input  wire logic [2:0]        mb_abort_done,
    input  wire logic              tx_end,
    input  wire logic [1:0]        tx_end_mb,
    input  wire logic              tx_end_ok,
    input  wire logic [3*ID_W-1:0] mb_ident,
    input  wire logic              fifo_full,
    input  wire logic              rx_accept,
    output logic                   time_triggered_enable,
    output logic                   no_retransmit,
    output logic                   tx_order_by_request,
    output logic                   fifo_lock_on_overrun,
    output logic                   bus_enable,
    output logic                   busoff_active,
    output logic                   fifo_store,
    output logic                   fifo_overwrite,
    output logic                   tx_next_valid,
    output logic [1:0]             tx_next_mb,
    output logic                   status_change_irq
);
    cmt_pkg::cmt_mode_t mode_q;
    cmt_pkg::cmt_mode_t mode_d;
    logic [7:0]         ctl_q;
    logic               wkf_q;
    logic               erf_q;
    logic               init_acknowledge_q;
    logic               acting_receiver_q;
    logic               acting_tx_q;
    logic [2:0]         pend_q;
    logic [2:0]         rqcp_q;
    logic [2:0]         txok_q;
    logic [2:0]         older_q [3];
    logic               boff_pend_q;
    logic [3:0]         rec_bits_q;
    logic [7:0]         rec_grp_q;
    logic               rx_meta_q;
    logic               rx_sync_q;
    logic               rx_prev_q;
    logic [31:0]        rdata_q;
    logic               slverr_q;
    logic [1:0]         nxt_mb_q;
    logic               nxt_v_q;
    logic               sof;
    logic               wake_clr;
    logic               cnt_en;
    logic [7:0]         rec_target;
    logic               rec_done;
    logic               wr_en;
    logic               setup;
    logic               sleep_acknowledge;
    logic [2:0]         end_c;
    logic [2:0]         rqcp_clr;
    logic [2:0]         low_c;
    logic [2:0]         top_c;
    logic [2:0]         low_flags;
    logic [1:0]         code_c;
    logic [7:0]         rd_c;
    logic               map_c;

    function automatic logic beats(input int i, input int j);
        logic [ID_W-1:0] a;
        logic [ID_W-1:0] b;
        a = mb_ident[i*ID_W +: ID_W];
        b = mb_ident[j*ID_W +: ID_W];
        if (ctl_q[`CMT_B_TXO])
            beats = older_q[i][j] | (!older_q[j][i] & (i < j));
        else
            beats = (a < b) | ((a == b) & (i < j));
    endfunction : beats

    // Pin synchroniser and start-of-frame edge
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            rx_meta_q <= 1'b1;
            rx_sync_q <= 1'b1;
            rx_prev_q <= 1'b1;
        end
        else
        begin
            rx_meta_q <= can_rx;
            rx_sync_q <= rx_meta_q;
            rx_prev_q <= rx_sync_q;
        end
    end
    assign sof = rx_prev_q & ~rx_sync_q;

    // Recessive bit run counting
    assign cnt_en     = (mode_q == cmt_pkg::CMT_SYNC) ||
                        ((mode_q == cmt_pkg::CMT_BUSOFF) && ctl_q[`CMT_B_ABO]);
    assign rec_target = boff_pend_q ? `CMT_BOFF_GRPS : `CMT_SYNC_GRPS;
    assign rec_done   = cnt_en && (rec_grp_q >= rec_target);

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            rec_bits_q <= 4'h0;
            rec_grp_q  <= 8'h00;
        end
        else if (!cnt_en || (mode_d != mode_q))
        begin
            rec_bits_q <= 4'h0;
            rec_grp_q  <= 8'h00;
        end
        else if (bit_tick && !rec_done)
        begin
            if (!rx_sync_q)
                rec_bits_q <= 4'h0;
            else if (rec_bits_q == `CMT_SYNC_BITS)
            begin
                rec_bits_q <= 4'h0;
                rec_grp_q  <= rec_grp_q + 8'h01;
            end
            else
                rec_bits_q <= rec_bits_q + 4'h1;
        end
    end

    // Operating mode
    always_comb
    begin
        mode_d   = mode_q;
        wake_clr = 1'b0;
        unique case (mode_q)
            cmt_pkg::CMT_SLEEP:
            begin
                if (ctl_q[`CMT_B_AWU] && sof)
                begin
                    wake_clr = 1'b1;
                    mode_d   = ctl_q[`CMT_B_INR] ? cmt_pkg::CMT_INIT : cmt_pkg::CMT_SYNC;
                end
                else if (!ctl_q[`CMT_B_SLP])
                    mode_d = ctl_q[`CMT_B_INR] ? cmt_pkg::CMT_INIT : cmt_pkg::CMT_SYNC;
            end
            cmt_pkg::CMT_INIT:
            begin
                if (!ctl_q[`CMT_B_INR])
                    mode_d = ctl_q[`CMT_B_SLP] ? cmt_pkg::CMT_SLEEP : cmt_pkg::CMT_SYNC;
            end
            cmt_pkg::CMT_SYNC:
            begin
                if (ctl_q[`CMT_B_INR])
                    mode_d = cmt_pkg::CMT_INIT;
                else if (ctl_q[`CMT_B_SLP])
                    mode_d = cmt_pkg::CMT_SLEEP;
                else if (rec_done)
                    mode_d = cmt_pkg::CMT_NORMAL;
            end
            cmt_pkg::CMT_NORMAL:
            begin
                if (tx_error_counter > `CMT_TEC_LIMIT)
                    mode_d = cmt_pkg::CMT_BUSOFF;
                else if (!bus_busy && ctl_q[`CMT_B_INR])
                    mode_d = cmt_pkg::CMT_INIT;
                else if (!bus_busy && ctl_q[`CMT_B_SLP])
                    mode_d = cmt_pkg::CMT_SLEEP;
            end
            cmt_pkg::CMT_BUSOFF:
            begin
                if (ctl_q[`CMT_B_ABO] && rec_done)
                    mode_d = cmt_pkg::CMT_NORMAL;
                else if (!ctl_q[`CMT_B_ABO] && ctl_q[`CMT_B_INR])
                    mode_d = cmt_pkg::CMT_INIT;
            end
            default:
                mode_d = cmt_pkg::CMT_SLEEP;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            mode_q <= cmt_pkg::CMT_SLEEP;
        else
            mode_q <= mode_d;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            boff_pend_q <= 1'b0;
        else if (mode_d == cmt_pkg::CMT_BUSOFF)
            boff_pend_q <= 1'b1;
        else if (mode_d == cmt_pkg::CMT_NORMAL)
            boff_pend_q <= 1'b0;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            init_acknowledge_q <= 1'b0;
        else if (mode_d == cmt_pkg::CMT_INIT)
            init_acknowledge_q <= 1'b1;
        else if ((mode_d == cmt_pkg::CMT_NORMAL) || (mode_d == cmt_pkg::CMT_SLEEP))
            init_acknowledge_q <= 1'b0;
    end

    assign sleep_acknowledge          = (mode_q == cmt_pkg::CMT_SLEEP);
    assign bus_enable    = (mode_q == cmt_pkg::CMT_NORMAL);
    assign busoff_active = (mode_q == cmt_pkg::CMT_BUSOFF);

    // APB access
    assign setup   = psel & ~penable;
    assign pready  = psel & penable;
    assign wr_en   = psel & penable & pwrite & pstrb[0];
    assign prdata  = rdata_q;
    assign pslverr = slverr_q;

    // Control register
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            ctl_q <= `CMT_MCR_RST;
        else
        begin
            if (wr_en && (paddr == `CMT_OFF_MCR))
                ctl_q <= pwdata[7:0];
            if (wake_clr)
                ctl_q[`CMT_B_SLP] <= 1'b0;
        end
    end
    assign time_triggered_enable = ctl_q[`CMT_B_TTE];
    assign no_retransmit         = ctl_q[`CMT_B_NRT];
    assign tx_order_by_request   = ctl_q[`CMT_B_TXO];
    assign fifo_lock_on_overrun  = ctl_q[`CMT_B_FLK];
    assign fifo_store     = rx_accept & bus_enable & ~fifo_full;
    assign fifo_overwrite = rx_accept & bus_enable & fifo_full & ~ctl_q[`CMT_B_FLK];

    // Master status flags
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            wkf_q             <= 1'b0;
            erf_q             <= 1'b0;
            acting_receiver_q <= 1'b0;
            acting_tx_q       <= 1'b0;
        end
        else
        begin
            acting_receiver_q <= role_rx;
            acting_tx_q       <= role_tx;
            if (sleep_acknowledge && sof)
                wkf_q <= 1'b1;
            else if (wr_en && (paddr == `CMT_OFF_MSR) && pwdata[`CMT_B_WKF])
                wkf_q <= 1'b0;
            if (|(err_status_set & err_status_en))
                erf_q <= 1'b1;
            else if (wr_en && (paddr == `CMT_OFF_MSR) && pwdata[`CMT_B_ERF])
                erf_q <= 1'b0;
        end
    end
    assign status_change_irq = (wkf_q & wakeup_irq_enable) | (erf_q & error_irq_enable);

    // Mailbox state
    always_comb
    begin
        for (int i = 0; i < 3; i++)
        begin
            end_c[i]    = tx_end && (tx_end_mb == 2'(i)) && (tx_end_ok || ctl_q[`CMT_B_NRT]);
            rqcp_clr[i] = wr_en && (paddr == `CMT_OFF_TSR) && pwdata[i];
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pend_q <= 3'h0;
            rqcp_q <= 3'h0;
            txok_q <= 3'h0;
        end
        else
        begin
            for (int i = 0; i < 3; i++)
            begin
                if (mb_tx_req[i])
                    pend_q[i] <= 1'b1;
                else if (end_c[i] || mb_abort_done[i])
                    pend_q[i] <= 1'b0;
                if (end_c[i] || mb_abort_done[i])
                    rqcp_q[i] <= 1'b1;
                else if (rqcp_clr[i])
                    rqcp_q[i] <= 1'b0;
                if (end_c[i] && tx_end_ok)
                    txok_q[i] <= 1'b1;
                else if (mb_tx_req[i] || (rqcp_clr[i] && !mb_abort_done[i]))
                    txok_q[i] <= 1'b0;
            end
        end
    end

    // Request order: older_q[i][j] set when i was requested before j
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            for (int i = 0; i < 3; i++)
                older_q[i] <= 3'h0;
        end
        else
        begin
            for (int i = 0; i < 3; i++)
            begin
                for (int j = 0; j < 3; j++)
                begin
                    if (mb_tx_req[j] && !mb_tx_req[i] && (i != j))
                        older_q[i][j] <= 1'b1;
                    else if (mb_tx_req[i])
                        older_q[i][j] <= 1'b0;
                end
            end
        end
    end

    // Priority ranking
    always_comb
    begin
        for (int i = 0; i < 3; i++)
        begin
            low_c[i] = pend_q[i];
            top_c[i] = pend_q[i];
            for (int j = 0; j < 3; j++)
            begin
                if ((j != i) && pend_q[j])
                begin
                    low_c[i] = low_c[i] & beats(j, i);
                    top_c[i] = top_c[i] & beats(i, j);
                end
            end
        end
        low_flags = ($countones(pend_q) > 1) ? low_c : 3'h0;
        if (!pend_q[0])
            code_c = 2'h0;
        else if (!pend_q[1])
            code_c = 2'h1;
        else if (!pend_q[2])
            code_c = 2'h2;
        else
            code_c = low_c[2] ? 2'h2 : (low_c[1] ? 2'h1 : 2'h0);
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            nxt_mb_q <= 2'h0;
            nxt_v_q  <= 1'b0;
        end
        else
        begin
            nxt_v_q  <= |top_c & (mode_d == cmt_pkg::CMT_NORMAL);
            nxt_mb_q <= top_c[2] ? 2'h2 : (top_c[1] ? 2'h1 : 2'h0);
        end
    end
    assign tx_next_valid = nxt_v_q;
    assign tx_next_mb    = nxt_mb_q;

    // Read mux, reserved bits zero
    always_comb
    begin
        rd_c  = 8'h00;
        map_c = 1'b1;
        unique case (paddr)
            `CMT_OFF_MCR: rd_c = ctl_q;
            `CMT_OFF_MSR: rd_c = {2'b00, acting_receiver_q, acting_tx_q, wkf_q, erf_q, sleep_acknowledge, init_acknowledge_q};
            `CMT_OFF_TSR: rd_c = {1'b0, txok_q, 1'b0, rqcp_q};
            `CMT_OFF_TPR: rd_c = {low_flags, ~pend_q, code_c};
            default:      map_c = 1'b0;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            rdata_q  <= 32'h0000_0000;
            slverr_q <= 1'b0;
        end
        else if (setup)
        begin
            rdata_q  <= {24'h00_0000, rd_c};
            slverr_q <= ~map_c;
        end
    end

    // Checks
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    a_init_entry_wait: assert property (
        (bus_enable && bus_busy) |=> !init_acknowledge_q && !sleep_acknowledge)
        else $error("mode left during a frame");
    a_init_ack_set: assert property (
        (bus_enable && !bus_busy && ctl_q[0] && tx_error_counter <= 9'h0FF) |=> init_acknowledge_q)
        else $error("init acknowledge missing");
    a_sync_groups: assert property (
        $rose(bus_enable) && !$past(boff_pend_q) |-> $past(rec_grp_q) == 8'h01)
        else $error("normal entered without recessive run");
    a_boff_recovery: assert property (
        $rose(bus_enable) && $past(boff_pend_q) |-> $past(rec_grp_q) == 8'h80)
        else $error("bus-off left too early");
    a_busoff_entry: assert property (
        (bus_enable && tx_error_counter > 9'h0FF) |=> busoff_active && !bus_enable && !tx_next_valid)
        else $error("bus-off not entered");
    a_auto_wake: assert property (
        (sleep_acknowledge && sof && ctl_q[5]) |=> !ctl_q[1] && !sleep_acknowledge && wkf_q)
        else $error("auto wake-up failed");
    a_sleep_hold: assert property (
        (sleep_acknowledge && !ctl_q[5] && ctl_q[1]) |=> sleep_acknowledge)
        else $error("sleep left without request clear");
    a_w1c_zero: assert property (
        (wkf_q && wr_en && paddr == 8'h04 && !pwdata[3]) |=> wkf_q)
        else $error("write of zero cleared wake flag");
    a_no_retx_once: assert property (
        (tx_end && !tx_end_ok && ctl_q[4] && tx_end_mb == 2'h0 && !mb_tx_req[0]) |=> !pend_q[0] && rqcp_q[0])
        else $error("message not dropped after one attempt");
    a_retx_keep: assert property (
        (pend_q[1] && tx_end && !tx_end_ok && !ctl_q[4] && tx_end_mb == 2'h1 && !mb_abort_done[1]) |=> pend_q[1])
        else $error("failed message dropped");
    a_txok_clear: assert property (
        (mb_tx_req[2] && !(tx_end && tx_end_mb == 2'h2)) |=> !txok_q[2] ##0 pend_q[2])
        else $error("success bit kept on new request");
    a_rqcp_sticky: assert property (
        (rqcp_q[0] && !rqcp_clr[0]) |=> rqcp_q[0])
        else $error("request done bit lost");
    a_low_single: assert property (
        ($past(setup) && ($past(paddr) == 8'h0C) && ($countones($past(pend_q)) < 2)) |-> rdata_q[7:5] == 3'h0)
        else $error("lowest flags set with one pending");

    c_auto_wake: cover property (sleep_acknowledge && sof && ctl_q[5] ##1 !sleep_acknowledge);
    c_boff_exit: cover property (busoff_active ##1 1'b1 [*1] ##[1:1000] bus_enable);
    c_all_pending: cover property (pend_q == 3'h7 && low_flags != 3'h0);
endmodule : cmt_ctrl

/* rtl/cmt_params.svh */
// Purpose: Constants for the CAN mode and transmit status control block
// Assumes: APB slave, 8-bit registers in the low byte of each word
// Notes: Functional notes follow
`ifndef CMT_PARAMS_SVH
`define CMT_PARAMS_SVH
`define CMT_OFF_MCR     8'h00
`define CMT_OFF_MSR     8'h04
`define CMT_OFF_TSR     8'h08
`define CMT_OFF_TPR     8'h0C
`define CMT_MCR_RST     8'h02
`define CMT_B_TTE       7
`define CMT_B_ABO       6
`define CMT_B_AWU       5
`define CMT_B_NRT       4
`define CMT_B_FLK       3
`define CMT_B_TXO       2
`define CMT_B_SLP       1
`define CMT_B_INR       0
`define CMT_B_WKF       3
`define CMT_B_ERF       2
`define CMT_SYNC_BITS   4'hA
`define CMT_BOFF_GRPS   8'h80
`define CMT_SYNC_GRPS   8'h01
`define CMT_TEC_LIMIT   9'h0FF
`endif

/* rtl/cmt_pkg.sv */
// Purpose: Types for the CAN mode and transmit status control block
// Assumes: Nothing
// Notes: Gray codes along sleep, init, sync, normal, bus-off
package cmt_pkg;
    typedef enum logic [2:0] {
        CMT_SLEEP  = 3'h0,
        CMT_INIT   = 3'h1,
        CMT_SYNC   = 3'h3,
        CMT_NORMAL = 3'h2,
        CMT_BUSOFF = 3'h6
    } cmt_mode_t;
endpackage : cmt_pkg

/* bench/cmt_bus_model.sv */
// Purpose: Far-side CAN bus model giving bit sample ticks and the rx level
// Assumes: Bus idles recessive
// Notes: A start-of-frame request holds the bus dominant for four bits
`timescale 1ns/1ps
module cmt_bus_model (
    input  wire logic pclk,
    input  wire logic presetn,
    input  wire logic sof_req,
    output logic      can_rx,
    output logic      bit_tick
);
    logic [1:0] div_q;
    logic [2:0] dom_q;
    // One sample point every four clocks
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            div_q <= 2'h0;
        else
            div_q <= div_q + 2'h1;
    end
    assign bit_tick = (div_q == 2'h3);
    // Dominant burst on request
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            dom_q <= 3'h0;
        else if (sof_req)
            dom_q <= 3'h4;
        else if (bit_tick && dom_q != 3'h0)
            dom_q <= dom_q - 3'h1;
    end
    assign can_rx = (dom_q == 3'h0);
endmodule : cmt_bus_model

/* bench/can_mode_and_tx_status_control_tb.sv */
// Purpose: Self-checking bench for the CAN mode and transmit status block
// Assumes: Zero-wait APB slave, bus model ticks every four clocks
// Notes: One task per scenario
`timescale 1ns/1ps
module can_mode_and_tx_status_control_tb;
    logic        pclk = 1'b0;
    logic        presetn = 1'b0;
    logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0, sof_req = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rd_q;
    logic        pready, pslverr, err_q, can_rx, bit_tick, tte, nrt, txo, flk, bus_en, irq, nxt_v;
    logic        fst, fow, boff;
    logic        role_tx = 1'b0, tx_end = 1'b0, tx_ok = 1'b0;
    logic        bus_busy = 1'b0, role_rx = 1'b0, ff = 1'b0, acc = 1'b0;
    logic [1:0]  tx_mb = 2'h0, nxt_mb;
    logic [2:0]  req = 3'h0, abt = 3'h0;
    logic [3:0]  es = 4'h0;
    logic [86:0] ids = {29'h7, 29'h3, 29'h5};
    int          n_fail = 0;
    int          check_count = 0;
    always #5 pclk = ~pclk;
    cmt_bus_model i_bus (.pclk(pclk), .presetn(presetn), .sof_req(sof_req), .can_rx(can_rx), .bit_tick(bit_tick));
    cmt_ctrl i_dut (
        .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
        .pwdata(pwdata), .pstrb(4'hF), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .can_rx(can_rx), .bit_tick(bit_tick), .bus_busy(bus_busy), .tx_error_counter(9'h000),
        .err_status_set(es), .err_status_en(4'h1), .wakeup_irq_enable(1'b1), .error_irq_enable(1'b1),
        .role_rx(role_rx), .role_tx(role_tx), .mb_tx_req(req), .mb_abort_done(abt), .tx_end(tx_end),
        .tx_end_mb(tx_mb), .tx_end_ok(tx_ok), .mb_ident(ids), .fifo_full(ff), .rx_accept(acc),
        .time_triggered_enable(tte), .no_retransmit(nrt), .tx_order_by_request(txo),
        .fifo_lock_on_overrun(flk), .bus_enable(bus_en), .busoff_active(boff), .fifo_store(fst),
        .fifo_overwrite(fow), .tx_next_valid(nxt_v), .tx_next_mb(nxt_mb), .status_change_irq(irq));
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : end_of_test
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp)
        begin
            n_fail++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic apb(input logic wr, input logic [7:0] adr, input logic [7:0] dat);
        int n;
        n = 0;
        @(posedge pclk);
        psel   <= 1'b1;
        pwrite <= wr;
        paddr  <= adr;
        pwdata <= {24'h0, dat};
        @(posedge pclk);
        penable <= 1'b1;
        do
        begin
            @(posedge pclk);
            n++;
        end
        while (pready !== 1'b1 && n < 16);
        rd_q = prdata;
        err_q = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        if (pready !== 1'b1)
        begin
            n_fail++;
            end_of_test();
        end
    endtask : apb
    task automatic rd(input logic [7:0] adr, input logic [7:0] exp);
        apb(1'b0, adr, 8'h00);
        chk(rd_q, {24'h0, exp});
    endtask : rd
    task automatic poll(input logic [7:0] adr, input logic [7:0] exp);
        int n;
        n = 0;
        do
        begin
            apb(1'b0, adr, 8'h00);
            n++;
        end
        while (rd_q !== {24'h0, exp} && n < 60);
        chk(rd_q, {24'h0, exp});
        if (rd_q !== {24'h0, exp})
            end_of_test();
    endtask : poll
    task automatic ev(input logic [2:0] rq, input logic [2:0] ab, input logic te, input logic [1:0] mb,
                      input logic ok, input logic [3:0] er);
        @(posedge pclk);
        req    <= rq;
        abt    <= ab;
        tx_end <= te;
        tx_mb  <= mb;
        tx_ok  <= ok;
        es     <= er;
        @(posedge pclk);
        req    <= 3'h0;
        abt    <= 3'h0;
        tx_end <= 1'b0;
        es     <= 4'h0;
    endtask : ev
    task automatic t_reset();
        rd(8'h00, 8'h02);
        rd(8'h04, 8'h02);
        rd(8'h08, 8'h00);
        rd(8'h0C, 8'h1C);
        apb(1'b1, 8'h10, 8'hFF);
        chk({31'h0, err_q}, 32'h1);
        apb(1'b1, 8'h0C, 8'hFF);
        rd(8'h0C, 8'h1C);
        chk({31'h0, bus_en}, 32'h0);
        chk({31'h0, boff}, 32'h0);
    endtask : t_reset
    task automatic t_start();
        apb(1'b1, 8'h00, 8'h01);
        poll(8'h04, 8'h01);
        apb(1'b1, 8'h00, 8'h00);
        poll(8'h04, 8'h00);
        chk({31'h0, bus_en}, 32'h1);
        apb(1'b1, 8'h00, 8'h9C);
        rd(8'h00, 8'h9C);
        chk({28'h0, tte, nrt, flk, txo}, 32'hF);
        acc <= 1'b1;
        ff  <= 1'b1;
        @(posedge pclk);
        chk({30'h0, fst, fow}, 32'h0);
        apb(1'b1, 8'h00, 8'h00);
        @(posedge pclk);
        chk({30'h0, fst, fow}, 32'h1);
        ff <= 1'b0;
        @(posedge pclk);
        chk({30'h0, fst, fow}, 32'h2);
        acc <= 1'b0;
    endtask : t_start
    task automatic t_mbox();
        ev(3'h1, 3'h0, 1'b0, 2'h0, 1'b0, 4'h0);
        rd(8'h0C, 8'h19);
        ev(3'h2, 3'h0, 1'b0, 2'h0, 1'b0, 4'h0);
        rd(8'h0C, 8'h32);
        chk({29'h0, nxt_v, nxt_mb}, 32'h5);
        ev(3'h0, 3'h0, 1'b1, 2'h0, 1'b0, 4'h0);
        rd(8'h08, 8'h00);
        ev(3'h0, 3'h0, 1'b1, 2'h0, 1'b1, 4'h0);
        rd(8'h08, 8'h11);
        ev(3'h0, 3'h2, 1'b0, 2'h0, 1'b0, 4'h0);
        rd(8'h08, 8'h13);
        rd(8'h0C, 8'h1C);
        apb(1'b1, 8'h08, 8'h01);
        rd(8'h08, 8'h02);
    endtask : t_mbox
    task automatic t_once();
        apb(1'b1, 8'h00, 8'h14);
        ev(3'h4, 3'h0, 1'b0, 2'h0, 1'b0, 4'h0);
        rd(8'h0C, 8'h0C);
        ev(3'h1, 3'h0, 1'b0, 2'h0, 1'b0, 4'h0);
        rd(8'h0C, 8'h29);
        chk({29'h0, nxt_v, nxt_mb}, 32'h6);
        ev(3'h0, 3'h0, 1'b1, 2'h2, 1'b0, 4'h0);
        ev(3'h0, 3'h1, 1'b0, 2'h0, 1'b0, 4'h0);
        rd(8'h08, 8'h07);
        rd(8'h0C, 8'h1C);
        apb(1'b1, 8'h08, 8'h07);
        rd(8'h08, 8'h00);
        apb(1'b1, 8'h00, 8'h00);
    endtask : t_once
    task automatic t_err();
        @(posedge pclk);
        role_tx <= 1'b1;
        ev(3'h0, 3'h0, 1'b0, 2'h0, 1'b0, 4'h1);
        rd(8'h04, 8'h14);
        chk({31'h0, irq}, 32'h1);
        apb(1'b1, 8'h04, 8'h04);
        role_tx <= 1'b0;
        role_rx <= 1'b1;
        rd(8'h04, 8'h20);
        role_rx <= 1'b0;
    endtask : t_err
    task automatic t_wake();
        bus_busy <= 1'b1;
        apb(1'b1, 8'h00, 8'h22);
        rd(8'h04, 8'h00);
        bus_busy <= 1'b0;
        poll(8'h04, 8'h02);
        @(posedge pclk);
        sof_req <= 1'b1;
        @(posedge pclk);
        sof_req <= 1'b0;
        poll(8'h04, 8'h08);
        rd(8'h00, 8'h20);
        chk({31'h0, irq}, 32'h1);
        apb(1'b1, 8'h04, 8'h08);
        apb(1'b1, 8'h00, 8'h01);
        poll(8'h04, 8'h01);
        chk({31'h0, bus_en}, 32'h0);
    endtask : t_wake
    initial
    begin
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        t_reset();
        t_start();
        t_mbox();
        t_once();
        t_err();
        t_wake();
        end_of_test();
    end
endmodule : can_mode_and_tx_status_control_tb
